// ===== hdl/byte_buffer2.sv
// Two-entry byte buffer with registered ready and valid
`timescale 1ns/1ps
module byte_buffer2
  import duart_pins_pkg::*;
(
  // Clock and reset
  input  wire logic    ref_clk_i,
  input  wire logic    nrst_i,
  // Streams
  byte_stream_if.snk   in_s,
  byte_stream_if.src   out_s
);
  import duart_pins_pkg::*;

  logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
  logic [DATA_W-1:0] mem_next [BUF_DEPTH];
  logic              wr_ptr_reg;
  logic              wr_ptr_next;
  logic              rd_ptr_reg;
  logic              rd_ptr_next;
  logic [1:0]        count_reg;
  logic [1:0]        count_next;
  logic              ready_reg;
  logic              ready_next;
  logic              valid_reg;
  logic              valid_next;
  logic              push;
  logic              pop;

  assign in_s.ready  = ready_reg;
  assign out_s.valid = valid_reg;
  assign out_s.data  = mem_reg[rd_ptr_reg];

  always_comb begin
    push        = in_s.valid & ready_reg;
    pop         = valid_reg & out_s.ready;
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_s.data;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
    ready_next = (count_next != 2'(BUF_DEPTH));
    valid_next = (count_next != 2'h0);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      ready_reg  <= 1'b1;
      valid_reg  <= 1'b0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      ready_reg  <= ready_next;
      valid_reg  <= valid_next;
    end
  end
endmodule

// ===== hdl/byte_stream_if.sv
// Valid/ready byte stream between the serial engines and buffers
`timescale 1ns/1ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== hdl/duart_pins_pkg.sv
// Shared constants and state types for the dual UART pin block
package duart_pins_pkg;
  localparam int NUM_CHAN  = 2;
  localparam int CHAN_A    = 0;
  localparam int CHAN_B    = 1;
  localparam int DATA_W    = 8;
  localparam int BUF_DEPTH = 2;
  localparam int MCR_W     = 4;
  localparam int MSR_W     = 4;
  localparam int BAUD_W    = 10;

  // Modem control bit positions
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam int MCR_OUT1   = 2;
  localparam int MCR_IRQ_EN = 3;

  // Modem status bit positions (active high)
  localparam int MSR_CTS = 0;
  localparam int MSR_DSR = 1;
  localparam int MSR_RI  = 2;
  localparam int MSR_CD  = 3;

  localparam logic [MCR_W-1:0] MCR_RESET = 4'h0;

  // Bit timing at a 100 MHz clock
  localparam int CLK_HZ    = 100_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam logic [BAUD_W-1:0] BIT_CYCLES =
    BAUD_W'(CLK_HZ / BAUD_RATE);
  localparam logic [BAUD_W-1:0] BIT_LAST = BIT_CYCLES - 10'h001;
  localparam logic [BAUD_W-1:0] HALF_LAST =
    (BIT_CYCLES >> 1) - 10'h001;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_STOP
  } ser_state_t;
endpackage

// ===== hdl/duart_serial_modem_pins.sv
// Serial, modem and status pins of both channels of a dual UART
// Summary of operation
// - Bus select high: channel B interrupt pin carries that channel's interrupt.
// - Control bit 3 set: interrupt pin actively driven, output port 2 low.
// - Control bit 3 clear: interrupt pin tri-stated when bus select is high, output port 2 high.
// - Bus select low: channel B interrupt pin unused, held at zero.
// - Each channel has an active-low transmitter-ready output from transmit status.
// - Each channel has an active-low receiver-ready output from receive status.
// - Each channel drives an active-low request-to-send, software controlled.
// - Each channel drives an active-low terminal-ready, software controlled.
// - Each channel accepts an active-low clear-to-send, readable as input.
// - Set-ready, carrier, ring inputs readable; they never affect transfers.
// - Bus select high picks strobe bus, low picks read/write-line bus.
`timescale 1ns/1ps
module duart_serial_modem_pins
  import duart_pins_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Bus select pin and channel B interrupt source
  input  wire logic              bus_select_i,
  input  wire logic              chan_b_irq_req_i,
  // Modem control values per channel
  input  wire logic [MCR_W-1:0]  chan_a_modem_ctrl_i,
  input  wire logic [MCR_W-1:0]  chan_b_modem_ctrl_i,
  // Channel B interrupt and output port pins
  output logic                   chan_b_irq_out_o,
  output logic                   chan_b_irq_out_oe_o,
  output logic                   chan_b_output_port2_n_o,
  // Channel A host data
  input  wire logic [DATA_W-1:0] chan_a_tx_data_i,
  input  wire logic              chan_a_tx_valid_i,
  output logic                   chan_a_tx_accept_o,
  output logic [DATA_W-1:0]      chan_a_rx_data_o,
  output logic                   chan_a_rx_valid_o,
  input  wire logic              chan_a_rx_take_i,
  // Channel B host data
  input  wire logic [DATA_W-1:0] chan_b_tx_data_i,
  input  wire logic              chan_b_tx_valid_i,
  output logic                   chan_b_tx_accept_o,
  output logic [DATA_W-1:0]      chan_b_rx_data_o,
  output logic                   chan_b_rx_valid_o,
  input  wire logic              chan_b_rx_take_i,
  // Ready status pins
  output logic                   chan_a_tx_ready_n_o,
  output logic                   chan_a_rx_ready_n_o,
  output logic                   chan_b_tx_ready_n_o,
  output logic                   chan_b_rx_ready_n_o,
  // Channel A serial and modem pins
  input  wire logic              chan_a_serial_in_i,
  output logic                   chan_a_serial_out_o,
  output logic                   chan_a_request_send_n_o,
  output logic                   chan_a_terminal_ready_n_o,
  input  wire logic              chan_a_clear_send_n_i,
  input  wire logic              chan_a_set_ready_n_i,
  input  wire logic              chan_a_carrier_detect_n_i,
  input  wire logic              chan_a_ring_indicator_n_i,
  output logic [MSR_W-1:0]       chan_a_modem_status_o,
  // Channel B serial and modem pins
  input  wire logic              chan_b_serial_in_i,
  output logic                   chan_b_serial_out_o,
  output logic                   chan_b_request_send_n_o,
  output logic                   chan_b_terminal_ready_n_o,
  input  wire logic              chan_b_clear_send_n_i,
  input  wire logic              chan_b_set_ready_n_i,
  input  wire logic              chan_b_carrier_detect_n_i,
  input  wire logic              chan_b_ring_indicator_n_i,
  output logic [MSR_W-1:0]       chan_b_modem_status_o
);
  import duart_pins_pkg::*;

  // Per-channel views of the pins
  logic [MCR_W-1:0]  ctrl_in    [NUM_CHAN];
  logic [MSR_W-1:0]  modem_raw  [NUM_CHAN];
  logic [DATA_W-1:0] tx_data_in [NUM_CHAN];
  logic [DATA_W-1:0] rx_data_out[NUM_CHAN];
  logic [NUM_CHAN-1:0] ser_raw;
  logic [NUM_CHAN-1:0] tx_valid_in;
  logic [NUM_CHAN-1:0] tx_accept;
  logic [NUM_CHAN-1:0] rx_valid_out;
  logic [NUM_CHAN-1:0] rx_take;

  // Registered per-channel outputs
  logic [MCR_W-1:0]  modem_control_reg [NUM_CHAN];
  logic [MSR_W-1:0]  status_reg        [NUM_CHAN];
  logic [NUM_CHAN-1:0] ser_out_reg;
  logic [NUM_CHAN-1:0] tx_rdy_n_reg;
  logic [NUM_CHAN-1:0] rx_rdy_n_reg;
  logic [NUM_CHAN-1:0] rts_n_reg;
  logic [NUM_CHAN-1:0] dtr_n_reg;

  assign ctrl_in[CHAN_A]    = chan_a_modem_ctrl_i;
  assign ctrl_in[CHAN_B]    = chan_b_modem_ctrl_i;
  assign modem_raw[CHAN_A]  = {chan_a_carrier_detect_n_i,
                               chan_a_ring_indicator_n_i,
                               chan_a_set_ready_n_i,
                               chan_a_clear_send_n_i};
  assign modem_raw[CHAN_B]  = {chan_b_carrier_detect_n_i,
                               chan_b_ring_indicator_n_i,
                               chan_b_set_ready_n_i,
                               chan_b_clear_send_n_i};
  assign ser_raw            = {chan_b_serial_in_i, chan_a_serial_in_i};
  assign tx_data_in[CHAN_A] = chan_a_tx_data_i;
  assign tx_data_in[CHAN_B] = chan_b_tx_data_i;
  assign tx_valid_in        = {chan_b_tx_valid_i, chan_a_tx_valid_i};
  assign rx_take            = {chan_b_rx_take_i, chan_a_rx_take_i};

  assign chan_a_tx_accept_o        = tx_accept[CHAN_A];
  assign chan_b_tx_accept_o        = tx_accept[CHAN_B];
  assign chan_a_rx_data_o          = rx_data_out[CHAN_A];
  assign chan_b_rx_data_o          = rx_data_out[CHAN_B];
  assign chan_a_rx_valid_o         = rx_valid_out[CHAN_A];
  assign chan_b_rx_valid_o         = rx_valid_out[CHAN_B];
  assign chan_a_tx_ready_n_o       = tx_rdy_n_reg[CHAN_A];
  assign chan_b_tx_ready_n_o       = tx_rdy_n_reg[CHAN_B];
  assign chan_a_rx_ready_n_o       = rx_rdy_n_reg[CHAN_A];
  assign chan_b_rx_ready_n_o       = rx_rdy_n_reg[CHAN_B];
  assign chan_a_serial_out_o       = ser_out_reg[CHAN_A];
  assign chan_b_serial_out_o       = ser_out_reg[CHAN_B];
  assign chan_a_request_send_n_o   = rts_n_reg[CHAN_A];
  assign chan_b_request_send_n_o   = rts_n_reg[CHAN_B];
  assign chan_a_terminal_ready_n_o = dtr_n_reg[CHAN_A];
  assign chan_b_terminal_ready_n_o = dtr_n_reg[CHAN_B];
  assign chan_a_modem_status_o     = status_reg[CHAN_A];
  assign chan_b_modem_status_o     = status_reg[CHAN_B];

  // Bus select pin synchroniser and channel B interrupt pin
  logic bus_sel_meta_reg;
  logic bus_sel_reg;
  logic irq_out_reg;
  logic irq_out_next;
  logic irq_oe_reg;
  logic irq_oe_next;
  logic op2_n_reg;
  logic op2_n_next;

  assign chan_b_irq_out_o        = irq_out_reg;
  assign chan_b_irq_out_oe_o     = irq_oe_reg;
  assign chan_b_output_port2_n_o = op2_n_reg;

  always_comb begin
    op2_n_next   = ~modem_control_reg[CHAN_B][MCR_IRQ_EN];
    irq_out_next = chan_b_irq_req_i;
    irq_oe_next  = modem_control_reg[CHAN_B][MCR_IRQ_EN];
    if (!bus_sel_reg) begin
      irq_out_next = 1'b0;
      irq_oe_next  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      bus_sel_meta_reg <= 1'b0;
      bus_sel_reg      <= 1'b0;
      irq_out_reg      <= 1'b0;
      irq_oe_reg       <= 1'b1;
      op2_n_reg        <= 1'b1;
    end else begin
      bus_sel_meta_reg <= bus_select_i;
      bus_sel_reg      <= bus_sel_meta_reg;
      irq_out_reg      <= irq_out_next;
      irq_oe_reg       <= irq_oe_next;
      op2_n_reg        <= op2_n_next;
    end
  end

  // One serial engine pair per channel
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    byte_stream_if tx_host ();
    byte_stream_if tx_eng ();
    byte_stream_if rx_eng ();
    byte_stream_if rx_host ();

    byte_buffer2 u_tx_buf (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .in_s      (tx_host),
      .out_s     (tx_eng)
    );

    byte_buffer2 u_rx_buf (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .in_s      (rx_eng),
      .out_s     (rx_host)
    );

    assign tx_host.valid    = tx_valid_in[ch];
    assign tx_host.data     = tx_data_in[ch];
    assign tx_accept[ch]    = tx_host.ready;
    assign rx_host.ready    = rx_take[ch];
    assign rx_data_out[ch]  = rx_host.data;
    assign rx_valid_out[ch] = rx_host.valid;

    logic [MSR_W-1:0]  modem_meta_reg;
    logic              ser_meta_reg;
    logic              ser_in_reg;
    ser_state_t        tx_state_reg;
    ser_state_t        tx_state_next;
    logic [BAUD_W-1:0] tx_baud_reg;
    logic [BAUD_W-1:0] tx_baud_next;
    logic [2:0]        tx_bit_reg;
    logic [2:0]        tx_bit_next;
    logic [DATA_W-1:0] tx_shift_reg;
    logic [DATA_W-1:0] tx_shift_next;
    logic              ser_out_next;
    ser_state_t        rx_state_reg;
    ser_state_t        rx_state_next;
    logic [BAUD_W-1:0] rx_baud_reg;
    logic [BAUD_W-1:0] rx_baud_next;
    logic [2:0]        rx_bit_reg;
    logic [2:0]        rx_bit_next;
    logic [DATA_W-1:0] rx_shift_reg;
    logic [DATA_W-1:0] rx_shift_next;

    // Transmitter: start, eight data bits LSB first, stop
    always_comb begin
      tx_state_next = tx_state_reg;
      tx_baud_next  = tx_baud_reg + 10'h001;
      tx_bit_next   = tx_bit_reg;
      tx_shift_next = tx_shift_reg;
      ser_out_next  = ser_out_reg[ch];
      tx_eng.ready  = 1'b0;
      case (tx_state_reg)
        SER_IDLE: begin
          ser_out_next = 1'b1;
          tx_baud_next = 10'h000;
          if (tx_eng.valid) begin
            tx_eng.ready  = 1'b1;
            tx_shift_next = tx_eng.data;
            ser_out_next  = 1'b0;
            tx_state_next = SER_START;
          end
        end
        SER_START: begin
          if (tx_baud_reg == BIT_LAST) begin
            tx_baud_next  = 10'h000;
            tx_bit_next   = 3'h0;
            ser_out_next  = tx_shift_reg[0];
            tx_state_next = SER_DATA;
          end
        end
        SER_DATA: begin
          if (tx_baud_reg == BIT_LAST) begin
            tx_baud_next  = 10'h000;
            tx_shift_next = tx_shift_reg >> 1;
            tx_bit_next   = tx_bit_reg + 3'h1;
            ser_out_next  = tx_shift_next[0];
            if (tx_bit_reg == LAST_DATA_BIT) begin
              ser_out_next  = 1'b1;
              tx_state_next = SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (tx_baud_reg == BIT_LAST) begin
            tx_state_next = SER_IDLE;
          end
        end
        default: begin
          tx_state_next = SER_IDLE;
        end
      endcase
    end

    // Receiver: idle-high line, mid-bit sampling, bad stop dropped
    always_comb begin
      rx_state_next = rx_state_reg;
      rx_baud_next  = rx_baud_reg + 10'h001;
      rx_bit_next   = rx_bit_reg;
      rx_shift_next = rx_shift_reg;
      rx_eng.valid  = 1'b0;
      rx_eng.data   = rx_shift_reg;
      case (rx_state_reg)
        SER_IDLE: begin
          rx_baud_next = 10'h000;
          if (!ser_in_reg) begin
            rx_state_next = SER_START;
          end
        end
        SER_START: begin
          if (rx_baud_reg == HALF_LAST) begin
            rx_baud_next  = 10'h000;
            rx_bit_next   = 3'h0;
            rx_state_next = ser_in_reg ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          if (rx_baud_reg == BIT_LAST) begin
            rx_baud_next  = 10'h000;
            rx_shift_next = {ser_in_reg, rx_shift_reg[DATA_W-1:1]};
            rx_bit_next   = rx_bit_reg + 3'h1;
            if (rx_bit_reg == LAST_DATA_BIT) begin
              rx_state_next = SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (rx_baud_reg == BIT_LAST) begin
            rx_eng.valid  = ser_in_reg;
            rx_state_next = SER_IDLE;
          end
        end
        default: begin
          rx_state_next = SER_IDLE;
        end
      endcase
    end

    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        ser_meta_reg          <= 1'b1;
        ser_in_reg            <= 1'b1;
        modem_meta_reg        <= 4'hF;
        status_reg[ch]        <= 4'h0;
        modem_control_reg[ch] <= MCR_RESET;
        rts_n_reg[ch]         <= 1'b1;
        dtr_n_reg[ch]         <= 1'b1;
        tx_rdy_n_reg[ch]      <= 1'b1;
        rx_rdy_n_reg[ch]      <= 1'b1;
        ser_out_reg[ch]       <= 1'b1;
        tx_state_reg          <= SER_IDLE;
        tx_baud_reg           <= 10'h000;
        tx_bit_reg            <= 3'h0;
        tx_shift_reg          <= 8'h00;
        rx_state_reg          <= SER_IDLE;
        rx_baud_reg           <= 10'h000;
        rx_bit_reg            <= 3'h0;
        rx_shift_reg          <= 8'h00;
      end else begin
        ser_meta_reg          <= ser_raw[ch];
        ser_in_reg            <= ser_meta_reg;
        modem_meta_reg        <= modem_raw[ch];
        status_reg[ch]        <= ~modem_meta_reg;
        modem_control_reg[ch] <= ctrl_in[ch];
        rts_n_reg[ch]   <= ~modem_control_reg[ch][MCR_RTS];
        dtr_n_reg[ch]   <= ~modem_control_reg[ch][MCR_DTR];
        tx_rdy_n_reg[ch] <= ~tx_host.ready;
        rx_rdy_n_reg[ch] <= ~rx_host.valid;
        ser_out_reg[ch]       <= ser_out_next;
        tx_state_reg          <= tx_state_next;
        tx_baud_reg           <= tx_baud_next;
        tx_bit_reg            <= tx_bit_next;
        tx_shift_reg          <= tx_shift_next;
        rx_state_reg          <= rx_state_next;
        rx_baud_reg           <= rx_baud_next;
        rx_bit_reg            <= rx_bit_next;
        rx_shift_reg          <= rx_shift_next;
      end
    end
  end
endmodule

// ===== testbench/duart_pins_props.sv
// Concurrent checks on the pin behaviour of the dual UART block
`timescale 1ns/1ps
module duart_pins_props (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       bus_select_i,
  input wire logic       chan_b_irq_req_i,
  input wire logic [3:0] chan_a_modem_ctrl_i,
  input wire logic [3:0] chan_b_modem_ctrl_i,
  input wire logic       chan_b_irq_out_o,
  input wire logic       chan_b_irq_out_oe_o,
  input wire logic       chan_b_output_port2_n_o,
  input wire logic       chan_a_tx_accept_o,
  input wire logic       chan_b_tx_accept_o,
  input wire logic       chan_a_tx_ready_n_o,
  input wire logic       chan_b_tx_ready_n_o,
  input wire logic       chan_a_rx_valid_o,
  input wire logic       chan_b_rx_valid_o,
  input wire logic       chan_a_rx_ready_n_o,
  input wire logic       chan_b_rx_ready_n_o,
  input wire logic       chan_a_serial_out_o,
  input wire logic       chan_a_request_send_n_o,
  input wire logic       chan_b_request_send_n_o,
  input wire logic       chan_a_terminal_ready_n_o,
  input wire logic       chan_b_terminal_ready_n_o,
  input wire logic       chan_a_clear_send_n_i,
  input wire logic       chan_a_set_ready_n_i,
  input wire logic       chan_a_carrier_detect_n_i,
  input wire logic       chan_a_ring_indicator_n_i,
  input wire logic [3:0] chan_a_modem_status_o
);
  logic [2:0] up_reg;
  logic [2:0] up_next;
  logic       up;
  // Edges since reset release, so pipeline history is clean
  assign up_next = (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
  assign up = (up_reg == 3'h4);
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) up_reg <= 3'h0;
    else up_reg <= up_next;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_op2_follows_bit:
    assert property (up |-> chan_b_output_port2_n_o ==
      !$past(chan_b_modem_ctrl_i[3], 2)) else $error("port 2 pin wrong");
  a_irq_drive_mode:
    assert property (up |-> chan_b_irq_out_oe_o == (!$past(bus_select_i, 3)
      || $past(chan_b_modem_ctrl_i[3], 2))) else $error("irq enable wrong");
  a_irq_low_rwbus:
    assert property (up && !$past(bus_select_i, 3) |-> !chan_b_irq_out_o)
      else $error("irq pin not low");
  a_irq_carries_req:
    assert property (up && $past(bus_select_i, 3) && chan_b_irq_out_oe_o |->
      chan_b_irq_out_o == $past(chan_b_irq_req_i)) else $error("irq value");
  a_tx_ready_lag:
    assert property (up |-> {chan_a_tx_ready_n_o, chan_b_tx_ready_n_o} ==
      ~$past({chan_a_tx_accept_o, chan_b_tx_accept_o}))
      else $error("tx ready pin wrong");
  a_rx_ready_lag:
    assert property (up |-> {chan_a_rx_ready_n_o, chan_b_rx_ready_n_o} ==
      ~$past({chan_a_rx_valid_o, chan_b_rx_valid_o}))
      else $error("rx ready pin wrong");
  a_rts_follows_bit:
    assert property (up |-> {chan_a_request_send_n_o, chan_b_request_send_n_o}
      == ~{$past(chan_a_modem_ctrl_i[1], 2), $past(chan_b_modem_ctrl_i[1], 2)})
      else $error("request to send wrong");
  a_dtr_follows_bit:
    assert property (up |-> chan_a_terminal_ready_n_o ==
      !$past(chan_a_modem_ctrl_i[0], 2) && chan_b_terminal_ready_n_o ==
      !$past(chan_b_modem_ctrl_i[0], 2)) else $error("terminal ready wrong");
  a_status_copy:
    assert property (up |-> chan_a_modem_status_o == ~$past({
      chan_a_carrier_detect_n_i, chan_a_ring_indicator_n_i,
      chan_a_set_ready_n_i, chan_a_clear_send_n_i}, 2))
      else $error("modem status wrong");
  c_irq_live: cover property (bus_select_i && chan_b_irq_out_o);
  c_rx_word: cover property (chan_a_rx_valid_o && !chan_a_rx_ready_n_o);
  c_tx_start: cover property ($fell(chan_a_serial_out_o));
endmodule
bind duart_serial_modem_pins duart_pins_props chk (.*);

// ===== testbench/duart_serial_modem_pins_tb_top.sv
// Self-checking bench for the dual UART serial and modem pin block
`timescale 1ns/1ps
module duart_serial_modem_pins_tb_top;
  import duart_pins_pkg::*;
  localparam int LIM = 50000;
  logic            ref_clk_i = 1'b0;
  logic            nrst_i;
  logic            bus_sel;
  logic            irq;
  logic [1:0][3:0] ctl;
  logic [1:0][3:0] mp;
  logic [1:0][7:0] txd;
  logic [1:0]      txv;
  logic [1:0]      tk;
  wire  [1:0][7:0] rxd;
  wire  [1:0][7:0] pbt;
  wire  [1:0][3:0] st;
  wire  [1:0]      acc, rxv, trdy, rrdy, so, si, rts, dtr, pg;
  wire             irq_o, irq_oe, op2;
  logic [7:0]      qtx [2][$];
  logic [7:0]      qrx [2][$];
  int              fail_count = 0;
  int              tests_run = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  duart_serial_modem_pins dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .bus_select_i(bus_sel), .chan_b_irq_req_i(irq),
    .chan_a_modem_ctrl_i(ctl[0]), .chan_b_modem_ctrl_i(ctl[1]),
    .chan_b_irq_out_o(irq_o), .chan_b_irq_out_oe_o(irq_oe),
    .chan_b_output_port2_n_o(op2),
    .chan_a_tx_data_i(txd[0]), .chan_a_tx_valid_i(txv[0]),
    .chan_a_tx_accept_o(acc[0]), .chan_a_rx_data_o(rxd[0]),
    .chan_a_rx_valid_o(rxv[0]), .chan_a_rx_take_i(tk[0]),
    .chan_b_tx_data_i(txd[1]), .chan_b_tx_valid_i(txv[1]),
    .chan_b_tx_accept_o(acc[1]), .chan_b_rx_data_o(rxd[1]),
    .chan_b_rx_valid_o(rxv[1]), .chan_b_rx_take_i(tk[1]),
    .chan_a_tx_ready_n_o(trdy[0]), .chan_a_rx_ready_n_o(rrdy[0]),
    .chan_b_tx_ready_n_o(trdy[1]), .chan_b_rx_ready_n_o(rrdy[1]),
    .chan_a_serial_in_i(si[0]), .chan_a_serial_out_o(so[0]),
    .chan_a_request_send_n_o(rts[0]), .chan_a_terminal_ready_n_o(dtr[0]),
    .chan_a_clear_send_n_i(mp[0][0]), .chan_a_set_ready_n_i(mp[0][1]),
    .chan_a_ring_indicator_n_i(mp[0][2]),
    .chan_a_carrier_detect_n_i(mp[0][3]), .chan_a_modem_status_o(st[0]),
    .chan_b_serial_in_i(si[1]), .chan_b_serial_out_o(so[1]),
    .chan_b_request_send_n_o(rts[1]), .chan_b_terminal_ready_n_o(dtr[1]),
    .chan_b_clear_send_n_i(mp[1][0]), .chan_b_set_ready_n_i(mp[1][1]),
    .chan_b_ring_indicator_n_i(mp[1][2]),
    .chan_b_carrier_detect_n_i(mp[1][3]), .chan_b_modem_status_o(st[1]));
  serial_peer_model pa (.ref_clk_i(ref_clk_i), .line_i(so[0]),
    .line_o(si[0]), .got_o(pg[0]), .byte_o(pbt[0]));
  serial_peer_model pb (.ref_clk_i(ref_clk_i), .line_i(so[1]),
    .line_o(si[1]), .got_o(pg[1]), .byte_o(pbt[1]));

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic give_up(input string what);
    fail_count++;
    $display("BAD %0t timeout waiting for %s", $time, what);
    summarize();
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t level %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  // Pops the oldest note whenever a byte shows up
  always @(posedge ref_clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (pg[c] && qtx[c].size() > 0) cmp_byte(pbt[c], qtx[c].pop_front());
      else if (pg[c]) cmp_bit(1'b1, 1'b0);
      if (rxv[c] && tk[c] && qrx[c].size() > 0) cmp_byte(rxd[c], qrx[c].pop_front());
      else if (rxv[c] && tk[c]) cmp_bit(1'b1, 1'b0);
    end
  end

  // Five bytes back to back, the later ones meet a full buffer
  task automatic tx_run(input int c);
    logic [7:0] b;
    int         n;
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'h00 : ((i == 4) ? 8'hFF : 8'($urandom));
      qtx[c].push_back(b);
      txd[c] = b;
      txv[c] = 1'b1;
      for (n = 0; acc[c] !== 1'b1; n++) begin
        if (n == 2) cmp_bit(trdy[c], 1'b1);
        if (n == LIM) give_up("accept");
        @(negedge ref_clk_i);
      end
      @(negedge ref_clk_i);
    end
    txv[c] = 1'b0;
  endtask
  // Host stalls: third byte overflows, fourth is badly framed
  task automatic rx_run(input int c);
    logic [7:0] b;
    int         n;
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      if (i < 2 || i == 4) qrx[c].push_back(b);
      if (c == 0) pa.send(b, i == 3);
      else pb.send(b, i == 3);
      if (i == 2) begin
        cmp_bit(rrdy[c], 1'b0);
        tk[c] = 1'b1;
        for (n = 0; rxv[c] !== 1'b0; n++) begin
          if (n == LIM) give_up("drain");
          @(negedge ref_clk_i);
        end
        repeat (2) @(negedge ref_clk_i);
        cmp_bit(rrdy[c], 1'b1);
      end
    end
  endtask

  initial begin
    nrst_i = 1'b0;
    bus_sel = 1'b0;
    irq = 1'b0;
    ctl = '0;
    mp = '1;
    txd = '0;
    txv = '0;
    tk = '0;
    repeat (6) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    void'($urandom(83));
    repeat (2) @(negedge ref_clk_i);
    for (int c = 0; c < 2; c++) begin
      cmp_bit(trdy[c], 1'b0);
      cmp_bit(rrdy[c], 1'b1);
    end
    for (int i = 0; i < 32; i++) begin
      bus_sel = i[4];
      ctl[1] = i[3:0];
      ctl[0] = ~i[3:0];
      irq = 1'($urandom);
      mp = 8'($urandom);
      repeat (4) @(negedge ref_clk_i);
      cmp_bit(op2, !i[3]);
      cmp_bit(irq_oe, !i[4] || i[3]);
      if (i[3] || !i[4]) cmp_bit(irq_o, i[4] && irq);
      for (int c = 0; c < 2; c++) begin
        cmp_bit(rts[c], !ctl[c][1]);
        cmp_bit(dtr[c], !ctl[c][0]);
        cmp_byte({4'h0, st[c]}, {4'h0, ~mp[c]});
      end
    end
    fork
      tx_run(0);
      tx_run(1);
      rx_run(0);
      rx_run(1);
      repeat (40) begin
        repeat (1000) @(negedge ref_clk_i);
        mp = 8'($urandom);
      end
    join
    for (int n = 0; qtx[0].size() + qtx[1].size() + qrx[0].size()
         + qrx[1].size() > 0; n++) begin
      if (n == LIM) give_up("bytes");
      @(negedge ref_clk_i);
    end
    summarize();
  end

  initial begin
    repeat (95000) @(posedge ref_clk_i);
    give_up("end of run");
  end
endmodule

// ===== testbench/serial_peer_model.sv
// Behavioural serial peer: sends 8N1 frames and decodes what it hears
`timescale 1ns/1ps
module serial_peer_model (
  input  wire logic                         ref_clk_i,
  input  wire logic                         line_i,
  output logic                              line_o,
  output logic                              got_o,
  output logic [duart_pins_pkg::DATA_W-1:0] byte_o
);
  import duart_pins_pkg::*;
  initial begin
    line_o = 1'b1;
    got_o = 1'b0;
    byte_o = '0;
  end
  task automatic put_bit(input logic v);
    line_o = v;
    repeat (BIT_CYCLES) @(negedge ref_clk_i);
  endtask
  // LSB first; a low stop bit breaks framing on request
  task automatic send(input logic [7:0] b, input logic bad_stop);
    @(negedge ref_clk_i);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(b[i]);
    put_bit(!bad_stop);
    put_bit(1'b1);
  endtask
  // Mid-bit sampling, reports only well-framed bytes
  always begin
    @(negedge line_i);
    repeat (BIT_CYCLES >> 1) @(posedge ref_clk_i);
    if (!line_i) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge ref_clk_i);
        byte_o[i] = line_i;
      end
      repeat (BIT_CYCLES) @(posedge ref_clk_i);
      if (line_i) begin
        got_o <= 1'b1;
        @(posedge ref_clk_i);
        got_o <= 1'b0;
      end
    end
  end
endmodule
